// ===== pkg/spgm_pkg.sv
// constants, opcodes and carrier types of the serial program port
package spgm_pkg;

	// system clock and the minimum programmer waits, in milliseconds
	localparam real CLK_HZ             = 200.0e6;
	localparam real MS_PER_S           = 1000.0;
	localparam real PAGE_WRITE_WAIT_MS = 4.5;
	localparam real BYTE_WRITE_WAIT_MS = 9.0;
	localparam real ERASE_WAIT_MS      = 9.0;
	localparam real FUSE_WRITE_WAIT_MS = 4.5;

	// self-timed busy must end inside the programmer wait, so counts round down
	localparam int unsigned PAGE_WRITE_WAIT_CYC =
		int'($floor(PAGE_WRITE_WAIT_MS * CLK_HZ / MS_PER_S));
	localparam int unsigned BYTE_WRITE_WAIT_CYC =
		int'($floor(BYTE_WRITE_WAIT_MS * CLK_HZ / MS_PER_S));
	localparam int unsigned ERASE_WAIT_CYC =
		int'($floor(ERASE_WAIT_MS * CLK_HZ / MS_PER_S));
	localparam int unsigned FUSE_WRITE_WAIT_CYC =
		int'($floor(FUSE_WRITE_WAIT_MS * CLK_HZ / MS_PER_S));
	localparam int TMR_W = 24;

	// frame layout: four bytes, msb first, bit counter positions
	localparam int           BIT_CNT_W = 5;
	localparam logic [4:0]   FRAME_END = 5'h1F;
	localparam logic [4:0]   BYTE3_END = 5'h17;
	localparam logic [2:0]   BYTE_END  = 3'h7;

	// memory geometry fixed by the instruction fields
	localparam int WORD_AW     = 6;
	localparam int PAGE_AW     = 8;
	localparam int FLASH_AW    = PAGE_AW + WORD_AW;
	localparam int FLASH_PAGES = 1 << PAGE_AW;
	localparam int PAGE_WORDS  = 1 << WORD_AW;
	localparam int FLASH_WORDS = 1 << FLASH_AW;
	localparam int EEP_AW      = 10;
	localparam int EEP_BYTES   = 1 << EEP_AW;
	localparam int LOCK_W      = 6;

	// opcodes and selector fields
	localparam logic [7:0] OP_PROG     = 8'hAC;
	localparam logic [7:0] EN_KEY      = 8'h53;
	localparam logic [2:0] ERASE_TAG   = 3'h4;
	localparam logic [2:0] LOCK_TAG    = 3'h7;
	localparam logic [1:0] LOCK_B4_TAG = 2'h3;
	localparam logic [7:0] FUSE_LO_SEL = 8'hA0;
	localparam logic [7:0] FUSE_HI_SEL = 8'hA8;
	localparam logic [3:0] OP_RD_FL    = 4'h2;
	localparam logic [3:0] OP_LD_PG    = 4'h4;
	localparam logic [2:0] OP_LOW3     = 3'h0;
	localparam logic [7:0] OP_WR_PG    = 8'h4C;
	localparam logic [7:0] OP_RD_EE    = 8'hA0;
	localparam logic [7:0] OP_WR_EE    = 8'hC0;
	localparam logic [7:0] OP_RD_LOCK  = 8'h58;
	localparam logic [7:0] OP_RD_FUSE  = 8'h50;
	localparam logic [7:0] B2_ZERO     = 8'h00;
	localparam logic [7:0] B2_FUSE_HI  = 8'h08;
	localparam logic [7:0] OP_RD_SIG   = 8'h30;
	localparam logic [7:0] OP_RD_CAL   = 8'h38;

	// erased values
	localparam logic [7:0]  ERASED      = 8'hFF;
	localparam logic [15:0] ERASED_W    = 16'hFFFF;
	localparam logic [5:0]  LOCK_INIT   = 6'h3F;
	localparam logic [1:0]  LOCK_RD_PAD = 2'h3;

	// one instruction frame
	typedef struct packed {
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] b3;
		logic [7:0] b4;
	} spgm_frame_t;

	// kind of the self-timed write in progress
	typedef enum logic [1:0] {
		WK_FLASH,
		WK_EEP,
		WK_ERASE,
		WK_FUSE
	} spgm_wkind_t;

endpackage : spgm_pkg

// ===== rtl/spgm_sync.sv
// two-flop level synchroniser
module spgm_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta_q <= '0;
			q_out  <= '0;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end

endmodule : spgm_sync

// ===== rtl/spgm_serial_prog.sv
// serial programming port: frame shifter, decode, nonvolatile arrays and write timers

module spgm_serial_prog #(
	parameter int unsigned     PAGE_WRITE_WAIT_CYC = spgm_pkg::PAGE_WRITE_WAIT_CYC,
	parameter int unsigned     BYTE_WRITE_WAIT_CYC = spgm_pkg::BYTE_WRITE_WAIT_CYC,
	parameter int unsigned     ERASE_WAIT_CYC      = spgm_pkg::ERASE_WAIT_CYC,
	parameter int unsigned     FUSE_WRITE_WAIT_CYC = spgm_pkg::FUSE_WRITE_WAIT_CYC,
	parameter logic [3:0][7:0] SIG_BYTES           = 32'hFF4B_5A69, // arbitrary value
	parameter logic [3:0][7:0] CAL_BYTES           = 32'hA0A1_A2A3, // arbitrary value
	parameter logic [7:0]      FUSE_LO_INIT        = 8'hFF,
	parameter logic [7:0]      FUSE_HI_INIT        = 8'hFF
) (
	input  wire logic clk_sys_in,
	input  wire logic rst_n_in,
	input  wire logic sck_in,
	input  wire logic mosi_in,
	input  wire logic dev_reset_n_in,
	output logic      miso_out,
	output logic      busy_out,
	output logic      prog_enabled_out
);

	localparam int WAW = spgm_pkg::WORD_AW;
	localparam int TW  = spgm_pkg::TMR_W;

	// link-domain state
	logic [31:0]                    frm_q;
	logic [31:0]                    frm_d;
	logic [spgm_pkg::BIT_CNT_W-1:0] bit_cnt_q;
	logic                           prog_en_q;
	logic [7:0]                     out_sr_q;
	logic                           miso_q;
	logic [15:0]                    pbuf_q [spgm_pkg::PAGE_WORDS];
	spgm_pkg::spgm_frame_t          fr;
	spgm_pkg::spgm_frame_t          rv;

	// nonvolatile state: kept across sessions, so no reset; only the flags, lock and fuses get a power-on value, the arrays none
	logic [15:0]                       flash_q [spgm_pkg::FLASH_WORDS];
	logic [7:0]                        eep_q   [spgm_pkg::EEP_BYTES];
	logic [spgm_pkg::FLASH_PAGES-1:0]  fl_valid_q  = '0;
	logic [spgm_pkg::EEP_BYTES-1:0]    eep_valid_q = '0;
	logic [spgm_pkg::LOCK_W-1:0]       lock_q      = spgm_pkg::LOCK_INIT;
	logic [7:0]                        fuse_lo_q   = FUSE_LO_INIT;
	logic [7:0]                        fuse_hi_q   = FUSE_HI_INIT;

	// write hand-off to the system domain
	logic                  wr_tgl_q   = 1'b0;
	spgm_pkg::spgm_wkind_t wr_kind_q  = spgm_pkg::WK_FLASH;
	logic [7:0]            busy_pg_q  = '0;
	logic [9:0]            busy_ea_q  = '0;
	logic                  busy_s;

	// system-domain state
	logic          tgl_s;
	logic          tgl_seen_q;
	logic          busy_q;
	logic [TW-1:0] tmr_q;

	// decoded instruction at frame end
	logic       frame_end;
	logic       do_exec;
	logic       op_en;
	logic       op_erase;
	logic       op_lock;
	logic       op_fuse_lo;
	logic       op_fuse_hi;
	logic       op_ld_pg;
	logic       op_wr_pg;
	logic       op_wr_ee;
	logic [7:0] wpg;
	logic [9:0] wea;

	// shift path: incoming bit joins at the bottom, so the first bit ends up msb
	assign frm_d     = {frm_q[30:0], mosi_in};
	assign fr        = frm_d;
	assign rv        = {frm_d[23:0], spgm_pkg::B2_ZERO};
	assign frame_end = bit_cnt_q == spgm_pkg::FRAME_END;

	// decode masks only the fixed bits of each format
	assign op_en      = fr.b1 == spgm_pkg::OP_PROG && fr.b2 == spgm_pkg::EN_KEY;
	assign op_erase   = fr.b1 == spgm_pkg::OP_PROG
		&& fr.b2[7:5] == spgm_pkg::ERASE_TAG;
	assign op_lock    = fr.b1 == spgm_pkg::OP_PROG && fr.b2[7:5] == spgm_pkg::LOCK_TAG
		&& fr.b4[7:6] == spgm_pkg::LOCK_B4_TAG;
	assign op_fuse_lo = fr.b1 == spgm_pkg::OP_PROG && fr.b2 == spgm_pkg::FUSE_LO_SEL;
	assign op_fuse_hi = fr.b1 == spgm_pkg::OP_PROG && fr.b2 == spgm_pkg::FUSE_HI_SEL;
	assign op_ld_pg   = fr.b1[7:4] == spgm_pkg::OP_LD_PG
		&& fr.b1[2:0] == spgm_pkg::OP_LOW3;
	assign op_wr_pg   = fr.b1 == spgm_pkg::OP_WR_PG;
	assign op_wr_ee   = fr.b1 == spgm_pkg::OP_WR_EE;
	assign wpg        = {fr.b2[5:0], fr.b3[7:6]};
	assign wea        = {fr.b2[1:0], fr.b3};

	// nothing but the enable frame acts until enable has been taken
	assign do_exec = frame_end && prog_en_q;

	// selects the byte returned during byte four, from bytes one to three
	function automatic logic [7:0] read_byte(input spgm_pkg::spgm_frame_t f);
		logic [13:0] wa;
		logic [9:0]  ea;
		logic [15:0] w;
		logic [7:0]  r;
		wa = {f.b2[5:0], f.b3};
		ea = {f.b2[1:0], f.b3};
		w  = flash_q[wa];
		r  = f.b3;
		if (f.b1[7:4] == spgm_pkg::OP_RD_FL && f.b1[2:0] == spgm_pkg::OP_LOW3) begin
			if (!fl_valid_q[wa[13:6]]) begin
				r = spgm_pkg::ERASED;
			end else if (busy_s && wr_kind_q == spgm_pkg::WK_FLASH
				&& busy_pg_q == wa[13:6]) begin
				r = spgm_pkg::ERASED;
			end else begin
				r = f.b1[3] ? w[15:8] : w[7:0];
			end
		end else if (f.b1 == spgm_pkg::OP_RD_EE) begin
			if (!eep_valid_q[ea] || (busy_s && wr_kind_q == spgm_pkg::WK_EEP
				&& busy_ea_q == ea)) begin
				r = spgm_pkg::ERASED;
			end else begin
				r = eep_q[ea];
			end
		end else if (f.b1 == spgm_pkg::OP_RD_LOCK && f.b2 == spgm_pkg::B2_ZERO) begin
			r = {spgm_pkg::LOCK_RD_PAD, lock_q};
		end else if (f.b1 == spgm_pkg::OP_RD_FUSE && f.b2 == spgm_pkg::B2_ZERO) begin
			r = fuse_lo_q;
		end else if (f.b1 == spgm_pkg::OP_RD_LOCK && f.b2 == spgm_pkg::B2_FUSE_HI) begin
			r = fuse_hi_q;
		end else if (f.b1 == spgm_pkg::OP_RD_SIG) begin
			r = SIG_BYTES[f.b3[1:0]];
		end else if (f.b1 == spgm_pkg::OP_RD_CAL) begin
			r = CAL_BYTES[f.b3[1:0]];
		end
		return r;
	endfunction : read_byte

	// link framing; device reset high clears alignment, which is how a
	// programmer resynchronises even while the serial clock stands still
	always_ff @(posedge sck_in or posedge dev_reset_n_in) begin
		if (dev_reset_n_in) begin
			frm_q     <= '0;
			bit_cnt_q <= '0;
		end else begin
			frm_q     <= frm_d;
			bit_cnt_q <= bit_cnt_q + 1'b1;
		end
	end

	// programming enable latch, cleared whenever the device leaves reset
	always_ff @(posedge sck_in or posedge dev_reset_n_in) begin
		if (dev_reset_n_in) begin
			prog_en_q <= 1'b0;
		end else if (frame_end && op_en) begin
			prog_en_q <= 1'b1;
		end
	end

	// outgoing byte: echo of the byte just received, read data before byte four
	always_ff @(posedge sck_in or posedge dev_reset_n_in) begin
		if (dev_reset_n_in) begin
			out_sr_q <= '0;
		end else if (bit_cnt_q[2:0] == spgm_pkg::BYTE_END) begin
			if (bit_cnt_q == spgm_pkg::BYTE3_END && prog_en_q) begin
				out_sr_q <= read_byte(rv);
			end else begin
				out_sr_q <= frm_d[7:0];
			end
		end else begin
			out_sr_q <= {out_sr_q[6:0], 1'b0};
		end
	end

	// output changes half a cycle after the load, on the falling edge
	always_ff @(negedge sck_in or posedge dev_reset_n_in) begin
		if (dev_reset_n_in) begin
			miso_q <= 1'b0;
		end else begin
			miso_q <= out_sr_q[7];
		end
	end

	assign miso_out = miso_q;

	// page buffer: unloaded words stay erased so they cannot clear bits
	always_ff @(posedge sck_in or posedge dev_reset_n_in) begin
		if (dev_reset_n_in) begin
			for (int i = 0; i < spgm_pkg::PAGE_WORDS; i++) begin
				pbuf_q[i] <= spgm_pkg::ERASED_W;
			end
		end else if (do_exec && op_wr_pg) begin
			for (int i = 0; i < spgm_pkg::PAGE_WORDS; i++) begin
				pbuf_q[i] <= spgm_pkg::ERASED_W;
			end
		end else if (do_exec && op_ld_pg) begin
			if (fr.b1[3]) begin
				pbuf_q[fr.b3[5:0]][15:8] <= fr.b4;
			end else begin
				pbuf_q[fr.b3[5:0]][7:0] <= fr.b4;
			end
		end
	end

	// flash array: page commit writes every word of the page at once
	always_ff @(posedge sck_in) begin
		if (do_exec && op_wr_pg) begin
			for (int i = 0; i < spgm_pkg::PAGE_WORDS; i++) begin
				if (fl_valid_q[wpg]) begin
					flash_q[{wpg, WAW'(i)}] <= flash_q[{wpg, WAW'(i)}] & pbuf_q[i];
				end else begin
					flash_q[{wpg, WAW'(i)}] <= pbuf_q[i];
				end
			end
		end
	end

	// eeprom array: plain overwrite, the old value is erased in the same step
	always_ff @(posedge sck_in) begin
		if (do_exec && op_wr_ee) begin
			eep_q[wea] <= fr.b4;
		end
	end

	// erased flags stand in for the whole array, so erase is one step
	always_ff @(posedge sck_in) begin
		if (do_exec && op_erase) begin
			fl_valid_q  <= '0;
			eep_valid_q <= '0;
		end else if (do_exec && op_wr_pg) begin
			fl_valid_q[wpg] <= 1'b1;
		end else if (do_exec && op_wr_ee) begin
			eep_valid_q[wea] <= 1'b1;
		end
	end

	// lock bits only move toward programmed; erase is the only way back
	always_ff @(posedge sck_in) begin
		if (do_exec && op_erase) begin
			lock_q <= spgm_pkg::LOCK_INIT;
		end else if (do_exec && op_lock) begin
			lock_q <= lock_q & fr.b4[spgm_pkg::LOCK_W-1:0];
		end
	end

	// fuses are written whole; erase leaves them alone
	always_ff @(posedge sck_in) begin
		if (do_exec && op_fuse_lo) begin
			fuse_lo_q <= fr.b4;
		end
		if (do_exec && op_fuse_hi) begin
			fuse_hi_q <= fr.b4;
		end
	end

	// each self-timed write flips the toggle; kind and address are held with it
	always_ff @(posedge sck_in) begin
		if (do_exec && (op_wr_pg || op_wr_ee || op_erase || op_lock
			|| op_fuse_lo || op_fuse_hi)) begin
			wr_tgl_q  <= ~wr_tgl_q;
			busy_pg_q <= wpg;
			busy_ea_q <= wea;
			if (op_wr_pg) begin
				wr_kind_q <= spgm_pkg::WK_FLASH;
			end else if (op_wr_ee) begin
				wr_kind_q <= spgm_pkg::WK_EEP;
			end else if (op_erase) begin
				wr_kind_q <= spgm_pkg::WK_ERASE;
			end else begin
				wr_kind_q <= spgm_pkg::WK_FUSE;
			end
		end
	end

	// write event into the system domain
	spgm_sync #(
		.W(1)
	) u_tgl_sync (
		.clk_in   (clk_sys_in),
		.rst_n_in (rst_n_in),
		.d_in     (wr_tgl_q),
		.q_out    (tgl_s)
	);

	// busy level back to the link; needs link edges, which the next frame gives
	spgm_sync #(
		.W(1)
	) u_busy_sync (
		.clk_in   (sck_in),
		.rst_n_in (~dev_reset_n_in),
		.d_in     (busy_q),
		.q_out    (busy_s)
	);

	// enable state for the status output
	spgm_sync #(
		.W(1)
	) u_en_sync (
		.clk_in   (clk_sys_in),
		.rst_n_in (rst_n_in),
		.d_in     (prog_en_q),
		.q_out    (prog_enabled_out)
	);

	// self-timed write: busy lasts the wait count of the write kind
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			tgl_seen_q <= 1'b0;
			busy_q     <= 1'b0;
			tmr_q      <= '0;
		end else if (tgl_s != tgl_seen_q) begin
			tgl_seen_q <= tgl_s;
			busy_q     <= 1'b1;
			unique case (wr_kind_q)
				spgm_pkg::WK_FLASH: tmr_q <= TW'(PAGE_WRITE_WAIT_CYC - 1);
				spgm_pkg::WK_EEP:   tmr_q <= TW'(BYTE_WRITE_WAIT_CYC - 1);
				spgm_pkg::WK_ERASE: tmr_q <= TW'(ERASE_WAIT_CYC - 1);
				spgm_pkg::WK_FUSE:  tmr_q <= TW'(FUSE_WRITE_WAIT_CYC - 1);
			endcase
		end else if (busy_q) begin
			if (tmr_q == '0) begin
				busy_q <= 1'b0;
			end else begin
				tmr_q <= tmr_q - 1'b1;
			end
		end
	end

	assign busy_out = busy_q;

endmodule : spgm_serial_prog

// ===== sim/spgm_serial_prog_monitor.sv
// assertions on the serial program port, bound to its top module
module spgm_serial_prog_monitor #(
	parameter int unsigned PAGE_WRITE_WAIT_CYC = 60,
	parameter int unsigned BYTE_WRITE_WAIT_CYC = 80,
	parameter int unsigned ERASE_WAIT_CYC      = 80,
	parameter int unsigned FUSE_WRITE_WAIT_CYC = 60
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic sck_in,
	input wire logic mosi_in,
	input wire logic dev_reset_n_in,
	input wire logic miso_out,
	input wire logic busy_out,
	input wire logic prog_enabled_out
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [31:0] busy_len_q;
	logic [3:0]  low_cnt_q;
	logic [4:0]  edge_cnt_q;
	logic [7:0]  echo_q;
	logic        miso_rise_q;

	// busy stretch length, and how long the reset pin has stayed low
	always_ff @(posedge clk_sys_in) begin
		busy_len_q <= (!rst_n_in || !busy_out) ? '0 : busy_len_q + 32'h0000_0001;
		low_cnt_q  <= dev_reset_n_in ? '0 : low_cnt_q + {3'h0, low_cnt_q != 4'hF};
	end

	// frame position and the last eight bits taken; the pin clears them like the port
	always_ff @(posedge sck_in or posedge dev_reset_n_in) begin
		if (dev_reset_n_in) begin
			edge_cnt_q <= '0;
			echo_q     <= '0;
		end else begin
			edge_cnt_q <= edge_cnt_q + 5'h01;
			echo_q     <= {echo_q[6:0], mosi_in};
		end
	end

	// output level just before each rising edge, to catch a change on the wrong edge
	always_ff @(posedge sck_in) begin
		miso_rise_q <= miso_out;
	end

	a_echo_bytes: assert property (@(posedge sck_in) disable iff (dev_reset_n_in)
		(edge_cnt_q >= 5'h08 && edge_cnt_q <= 5'h17) |-> miso_out == echo_q[7])
		else $error("serial output does not echo the previous byte");
	a_miso_falls: assert property (@(negedge sck_in) disable iff (dev_reset_n_in || !rst_n_in)
		miso_out == miso_rise_q)
		else $error("serial output changed on a rising edge");
	a_busy_length: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$fell(busy_out) |-> busy_len_q == PAGE_WRITE_WAIT_CYC || busy_len_q == FUSE_WRITE_WAIT_CYC
		|| busy_len_q == BYTE_WRITE_WAIT_CYC || busy_len_q == ERASE_WAIT_CYC)
		else $error("busy lasted a wrong number of cycles");
	a_busy_stays: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(busy_out) |-> busy_out [*8])
		else $error("busy dropped right after rising");
	a_busy_enabled: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(busy_out) |-> prog_enabled_out)
		else $error("write started without programming enabled");
	a_enable_cleared: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		dev_reset_n_in [*4] |-> !prog_enabled_out)
		else $error("enable survived the reset pin going high");
	a_enable_held: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		low_cnt_q == 4'hF && $past(prog_enabled_out) |-> prog_enabled_out)
		else $error("enable dropped while the reset pin was low");
	a_miso_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		dev_reset_n_in && $past(dev_reset_n_in) |-> !miso_out)
		else $error("serial output driven outside programming");
endmodule : spgm_serial_prog_monitor

bind spgm_serial_prog spgm_serial_prog_monitor #(
	.PAGE_WRITE_WAIT_CYC(PAGE_WRITE_WAIT_CYC),
	.BYTE_WRITE_WAIT_CYC(BYTE_WRITE_WAIT_CYC),
	.ERASE_WAIT_CYC(ERASE_WAIT_CYC),
	.FUSE_WRITE_WAIT_CYC(FUSE_WRITE_WAIT_CYC)
) i_monitor (
	.clk_sys_in(clk_sys_in),
	.rst_n_in(rst_n_in),
	.sck_in(sck_in),
	.mosi_in(mosi_in),
	.dev_reset_n_in(dev_reset_n_in),
	.miso_out(miso_out),
	.busy_out(busy_out),
	.prog_enabled_out(prog_enabled_out)
);

// ===== sim/spgm_programmer.sv
// programmer model: drives frames and the reset pin, collects the serial answer
module spgm_programmer (
	output logic        sck_out,
	output logic        mosi_out,
	output logic        dev_reset_n_out,
	output logic        done_out,
	output logic [31:0] rx_out,
	input  wire logic   miso_in
);
	timeunit 1ns;
	timeprecision 100ps;

	// power-up with pin and clock low, then a short pulse to clear any stray framing
	initial begin
		sck_out = 1'b0;
		mosi_out = 1'b0;
		done_out = 1'b0;
		rx_out = '0;
		dev_reset_n_out = 1'b0;
		#5 dev_reset_n_out = 1'b1;
		#20 dev_reset_n_out = 1'b0;
	end

	// whole frame msb first; the clock only runs inside it, answer taken on rising edges
	// phases are fixed 3 ns halves; the port clocks on sck itself, not on sys ticks
	task automatic send(input spgm_pkg::spgm_frame_t f);
		for (int i = 31; i >= 0; i--) begin
			mosi_out = f[i];
			#3 sck_out = 1'b1;
			rx_out = {rx_out[30:0], miso_in};
			#3 sck_out = 1'b0;
		end
		mosi_out = ~mosi_out;
		done_out = 1'b1;
		#1 done_out = 1'b0;
	endtask : send

	// resync pulse on the reset pin, longer than two device cycles
	task automatic resync();
		#2 dev_reset_n_out = 1'b1;
		#20 dev_reset_n_out = 1'b0;
		#10;
	endtask : resync

	// end of session: reset pin released high
	task automatic release_pin();
		dev_reset_n_out = 1'b1;
	endtask : release_pin
endmodule : spgm_programmer

// ===== sim/test_serial_program_interface.sv
// self-checking bench: frames from the programmer model, answers checked in order
module test_serial_program_interface;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [3:0][7:0] SIG = 32'hFF12_3456; // arbitrary value
	localparam logic [3:0][7:0] CAL = 32'h8C9D_AEBF; // arbitrary value

	logic        clk_sys_in;
	logic        rst_n_in;
	logic        sck_in;
	logic        mosi_in;
	logic        dev_reset_n_in;
	logic        miso_out;
	logic        busy_out;
	logic        prog_enabled_out;
	logic        frame_done;
	logic [31:0] rx_word;
	logic [15:0] notes_q[$];
	logic [15:0] lfsr_q = 16'h53B8;
	int          n_errors = 0;
	int          comparisons = 0;
	logic [7:0]  a, d, p, w, lo, hi;

	spgm_serial_prog #(
		.PAGE_WRITE_WAIT_CYC(60),
		.BYTE_WRITE_WAIT_CYC(80),
		.ERASE_WAIT_CYC(80),
		.FUSE_WRITE_WAIT_CYC(60),
		.SIG_BYTES(SIG),
		.CAL_BYTES(CAL)
	) i_dut (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.sck_in(sck_in),
		.mosi_in(mosi_in),
		.dev_reset_n_in(dev_reset_n_in),
		.miso_out(miso_out),
		.busy_out(busy_out),
		.prog_enabled_out(prog_enabled_out)
	);

	spgm_programmer i_prog (
		.sck_out(sck_in),
		.mosi_out(mosi_in),
		.dev_reset_n_out(dev_reset_n_in),
		.done_out(frame_done),
		.rx_out(rx_word),
		.miso_in(miso_out)
	);

	// system clock, 5 ns
	initial begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	function automatic logic [7:0] rnd();
		lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		return lfsr_q[7:0];
	endfunction : rnd

	task automatic check_word(input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: answer %h, expected %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_bit(input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: status %b, expected %b", $time, got, exp);
		end
	endtask : check_bit

	// note echo of byte two and byte four answer, then send
	task automatic frame(input logic [7:0] b1, b2, b3, b4, e4);
		notes_q.push_back({b2, e4});
		i_prog.send({b1, b2, b3, b4});
	endtask : frame

	task automatic cmd(input logic [7:0] b1, b2, b3, b4);
		frame(b1, b2, b3, b4, b3);
	endtask : cmd

	task automatic rd(input logic [7:0] b1, b2, b3, e4);
		frame(b1, b2, b3, 8'h00, e4);
	endtask : rd

	// busy must (or must not) show, then end within a bounded count; the bench always
	// waits the write out instead of polling data, so all-ones data is safe
	task automatic wait_write(input logic exp);
		int n = 0;
		while (busy_out !== 1'b1 && n < 40) begin
			@(posedge clk_sys_in);
			n++;
		end
		check_bit(exp, busy_out);
		n = 0;
		while (busy_out !== 1'b0 && n < 400) begin
			@(posedge clk_sys_in);
			n++;
		end
		if (n == 400) begin
			n_errors++;
			$display("wrong value at %0t: write never finished", $time);
			tally_and_finish();
		end
	endtask : wait_write

	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	// each finished frame is matched with the oldest note
	always @(posedge frame_done) begin
		if (notes_q.size() == 0) begin
			n_errors++;
			$display("wrong value at %0t: answer with no note", $time);
		end else begin
			check_word(notes_q.pop_front(), rx_word[15:0]);
		end
	end

	// main sequence
	initial begin
		rst_n_in = 1'b0;
		repeat (3) @(posedge clk_sys_in);
		#1 rst_n_in = 1'b1;
		// power-up wait before the enable frame, scaled down to keep the run short
		#200;
		a = rnd();
		cmd(8'hC0, 8'h00, a, 8'h5A);
		wait_write(1'b0);
		rd(8'hA0, 8'h00, a, a);
		cmd(8'hAC, 8'h53, rnd(), rnd());
		repeat (4) @(posedge clk_sys_in);
		check_bit(1'b1, prog_enabled_out);
		for (int i = 0; i < 4; i++) begin
			rd(8'h30, rnd() & 8'h3F, (rnd() & 8'hFC) | 8'(i), SIG[i]);
			rd(8'h38, rnd(), 8'(i), CAL[i]);
		end
		$display("test ids done");
		a = rnd();
		d = rnd() & 8'h7F;
		cmd(8'hC0, 8'h02, a, d);
		rd(8'hA0, 8'h02 | (rnd() & 8'h3C), a, 8'hFF);
		wait_write(1'b1);
		rd(8'hA0, 8'h02, a, d);
		cmd(8'hC0, 8'h02, a, ~d);
		wait_write(1'b1);
		rd(8'hA0, 8'h02, a, ~d);
		$display("test eeprom done");
		p = rnd();
		w = rnd() & 8'h3F;
		lo = rnd() & 8'h7F;
		hi = rnd() & 8'h7F;
		cmd(8'h40, rnd() & 8'h3F, w, lo);
		cmd(8'h48, 8'h00, w | (rnd() & 8'hC0), hi);
		cmd(8'h4C, p >> 2, {p[1:0], 6'h15}, 8'h00);
		rd(8'h20, p >> 2, {p[1:0], w[5:0]}, 8'hFF);
		wait_write(1'b1);
		rd(8'h20, p >> 2, {p[1:0], w[5:0]}, lo);
		rd(8'h28, p >> 2, {p[1:0], w[5:0]}, hi);
		$display("test flash done");
		cmd(8'hAC, 8'hA0, rnd(), 8'h5E);
		wait_write(1'b1);
		cmd(8'hAC, 8'hA8, rnd(), 8'hD9);
		wait_write(1'b1);
		cmd(8'hAC, 8'hE0 | (rnd() & 8'h1F), rnd(), 8'hC3);
		wait_write(1'b1);
		rd(8'h50, 8'h00, rnd(), 8'h5E);
		rd(8'h58, 8'h08, rnd(), 8'hD9);
		rd(8'h58, 8'h00, rnd(), 8'hC3);
		cmd(8'hAC, 8'h80 | (rnd() & 8'h1F), rnd(), rnd());
		wait_write(1'b1);
		rd(8'hA0, 8'h02, a, 8'hFF);
		rd(8'h20, p >> 2, {p[1:0], w[5:0]}, 8'hFF);
		rd(8'h58, 8'h00, 8'h00, 8'hFF);
		rd(8'h50, 8'h00, 8'h00, 8'h5E);
		$display("test fuses lock erase done");
		i_prog.resync();
		repeat (4) @(posedge clk_sys_in);
		check_bit(1'b0, prog_enabled_out);
		rd(8'h30, 8'h00, 8'h02, 8'h02);
		cmd(8'hAC, 8'h53, 8'h00, 8'h00);
		rd(8'h30, 8'h00, 8'h00, SIG[0]);
		i_prog.release_pin();
		repeat (6) @(posedge clk_sys_in);
		check_bit(1'b0, prog_enabled_out);
		$display("test resync done");
		tally_and_finish();
	end
endmodule : test_serial_program_interface
